// *** hw/pss_storm_ctrl.sv ***
/*
 pss_storm_ctrl: per-port storm suppression between receive path and forwarding.
 assumes frames arrive one word per beat with class and length already decoded,
 and configuration is held stable by management logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - each of broadcast, multicast and unicast has its own enable, all off after reset.
// - percentage thresholds run 0 to 100.00 percent in hundredths of port bandwidth.
// - packet-rate thresholds run over the full 32-bit range with falling not above rising.
// - a storm starts once a class rate reaches its rising level and that class is then blocked.
// - a rising percentage of 100 means no limit and disables detection for the class.
// - a rising packet rate of all ones means no limit and disables detection for the class.
// - without a falling level, blocking ends once the rate drops below the rising level.
// - with a falling level, blocking ends once the rate drops below the falling level.
// - a filtered multicast or unicast storm blocks all three classes and passes spanning tree.
// - a filtered broadcast storm blocks broadcast only.
// - with shutdown selected, a detected storm disables the port.
// - with trap selected, a storm detection raises a one-cycle notification, one pulse for all classes detected in the same cycle.
// - trap and shutdown have independent enables.
// - after reset the action is filter only, with no notification.
module pss_storm_ctrl #(
   parameter int INTERVAL_CYCLES = pss_pkg::INTERVAL_CYC,
   parameter int PORT_MBPS = 1000
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // configuration, one entry per class, then port-wide actions and re-enable
   input wire pss_pkg::pss_class_cfg_t cfg_bcast,
   input wire pss_pkg::pss_class_cfg_t cfg_mcast,
   input wire pss_pkg::pss_class_cfg_t cfg_ucast,
   input wire logic act_shutdown,
   input wire logic act_trap,
   input wire logic port_reenable,
   // receive side
   input wire logic rx_valid,
   output logic rx_ready,
   input wire pss_pkg::pss_frame_t rx_frame,
   // forwarding side
   output logic fw_valid,
   input wire logic fw_ready,
   output pss_pkg::pss_frame_t fw_frame,
   // status
   output logic [2:0] storm_active,
   output logic port_disabled,
   output logic trap_event
);
   // refuse an interval too short to count in, or a port with no bandwidth
   if (INTERVAL_CYCLES < 2 || PORT_MBPS < 1) begin : g_bad_param
      $error("pss_storm_ctrl: bad parameters");
   end

   localparam int CNT_W = $clog2(INTERVAL_CYCLES + 1);
   // bytes per interval at line rate; 64 bits holds any sane speed
   localparam longint LINE_BYTES = longint'(PORT_MBPS) * 125000 * INTERVAL_CYCLES
                                   / pss_pkg::CLK_HZ;

   // percent (hundredths) of line bytes; the threshold is divided by PCT_FULL before the compare
   function automatic logic [63:0] pct_bytes(input logic [13:0] pct);
      pct_bytes = (64'(LINE_BYTES) * 64'(pct)) / 64'(pss_pkg::PCT_FULL);
   endfunction

   pss_pkg::pss_class_cfg_t cfg [3];
   assign cfg[0] = cfg_bcast;
   assign cfg[1] = cfg_mcast;
   assign cfg[2] = cfg_ucast;

   logic [CNT_W-1:0] tick_cnt_r;
   wire interval_end = (tick_cnt_r == CNT_W'(INTERVAL_CYCLES - 1));

   logic [31:0] pkt_cnt_r [3];
   logic [63:0] byte_cnt_r [3];
   pss_pkg::pss_state_t st_r [3];
   logic shut_r;
   logic trap_r;

   // two-entry skid buffer on the forwarding path
   pss_pkg::pss_frame_t buf_r [2];
   logic [1:0] buf_cnt_r;
   logic rd_ptr_r;
   logic wr_ptr_r;

   wire in_fire = rx_valid && rx_ready;
   wire [1:0] in_cls = rx_frame.cls;

   // blocking decision per incoming class
   wire bc_filter = (st_r[0] == pss_pkg::ST_STORM);
   wire mu_filter = (st_r[1] == pss_pkg::ST_STORM) || (st_r[2] == pss_pkg::ST_STORM);
   wire is_stp = (in_cls == pss_pkg::CLS_STP);
   wire drop_mu = mu_filter && !is_stp;
   wire drop_bc = bc_filter && (in_cls == pss_pkg::CLS_BCAST);
   wire drop = drop_mu || drop_bc || shut_r;
   wire push = in_fire && !drop;
   wire pop = fw_valid && fw_ready;

   assign rx_ready = (buf_cnt_r != 2'h2);
   assign fw_valid = (buf_cnt_r != 2'h0);
   assign fw_frame = buf_r[rd_ptr_r];
   assign port_disabled = shut_r;
   assign trap_event = trap_r;

   logic [2:0] rise_hit;
   logic [2:0] below_rel;
   logic [2:0] limited;
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (cfg[i].pps_mode) begin
            limited[i] = cfg[i].enable && (cfg[i].rise_pps != pss_pkg::PPS_FULL);
            rise_hit[i] = (pkt_cnt_r[i] >= cfg[i].rise_pps);
            // falling never above rising; clamp a bad setting to rising
            below_rel[i] = cfg[i].fall_valid && (cfg[i].fall_pps <= cfg[i].rise_pps)
                           ? (pkt_cnt_r[i] < cfg[i].fall_pps)
                           : (pkt_cnt_r[i] < cfg[i].rise_pps);
         end else begin
            limited[i] = cfg[i].enable && (cfg[i].rise_pct < pss_pkg::PCT_FULL);
            rise_hit[i] = (byte_cnt_r[i] >= pct_bytes(cfg[i].rise_pct));
            below_rel[i] = cfg[i].fall_valid && (cfg[i].fall_pct < cfg[i].rise_pct)
                           ? (byte_cnt_r[i] < pct_bytes(cfg[i].fall_pct))
                           : (byte_cnt_r[i] < pct_bytes(cfg[i].rise_pct));
         end
      end
   end

   wire [2:0] storm_start;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_cls
         assign storm_start[g] = interval_end && limited[g] && rise_hit[g]
                                 && (st_r[g] == pss_pkg::ST_IDLE);
         assign storm_active[g] = (st_r[g] == pss_pkg::ST_STORM);
      end
   endgenerate
   wire any_start = |storm_start;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_r <= '0;
      end else if (clk_en) begin
         tick_cnt_r <= interval_end ? '0 : tick_cnt_r + CNT_W'(1);
      end
   end

   // counting includes dropped frames: the rate is what arrives, not what passes
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 3; i++) begin
            pkt_cnt_r[i] <= '0;
            byte_cnt_r[i] <= '0;
            st_r[i] <= pss_pkg::ST_IDLE;
         end
      end else if (clk_en) begin
         for (int i = 0; i < 3; i++) begin
            if (interval_end) begin
               pkt_cnt_r[i] <= '0;
               byte_cnt_r[i] <= '0;
            end else if (in_fire && in_cls == 2'(i) && pkt_cnt_r[i] != '1) begin
               pkt_cnt_r[i] <= pkt_cnt_r[i] + 32'h1;
               byte_cnt_r[i] <= byte_cnt_r[i] + 64'(rx_frame.len);
            end
            case (st_r[i])
               pss_pkg::ST_IDLE: begin
                  if (storm_start[i]) begin
                     st_r[i] <= pss_pkg::ST_STORM;
                  end
               end
               pss_pkg::ST_STORM: begin
                  if (!limited[i] || (interval_end && below_rel[i])) begin
                     st_r[i] <= pss_pkg::ST_IDLE;
                  end
               end
               default: st_r[i] <= pss_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // shutdown is sticky until management re-enables; a new storm wins over re-enable
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shut_r <= 1'b0;
         trap_r <= 1'b0;
      end else if (clk_en) begin
         if (any_start && act_shutdown) begin
            shut_r <= 1'b1;
         end else if (port_reenable) begin
            shut_r <= 1'b0;
         end
         trap_r <= any_start && act_trap;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         buf_cnt_r <= 2'h0;
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
      end else if (clk_en) begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         buf_cnt_r <= buf_cnt_r + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clk_en && push) begin
         buf_r[wr_ptr_r] <= rx_frame;
      end
   end
endmodule // pss_storm_ctrl
`default_nettype wire

// *** hw/pss_pkg.sv ***
/*
 pss_pkg: shared types and constants for the port storm suppression block.
 assumes a 100 MHz core clock and a one-second measurement interval.
*/
package pss_pkg;
   localparam int NUM_CLASS = 3;
   localparam logic [1:0] CLS_BCAST = 2'h0;
   localparam logic [1:0] CLS_MCAST = 2'h1;
   localparam logic [1:0] CLS_UCAST = 2'h2;
   localparam logic [1:0] CLS_STP = 2'h3;
   // percentage in hundredths: 0..10000
   localparam logic [13:0] PCT_FULL = 14'h2710;
   localparam logic [31:0] PPS_FULL = 32'hFFFFFFFF;
   localparam int CLK_HZ = 100000000;
   localparam int INTERVAL_MS = 1000;
   localparam int INTERVAL_CYC = CLK_HZ / 1000 * INTERVAL_MS;
   localparam int DATA_W = 64;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [1:0] cls;
      logic [13:0] len;
   } pss_frame_t;

   typedef struct packed {
      logic enable;
      logic pps_mode;
      logic [13:0] rise_pct;
      logic [13:0] fall_pct;
      logic fall_valid;
      logic [31:0] rise_pps;
      logic [31:0] fall_pps;
   } pss_class_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STORM = 2'b01
   } pss_state_t;
endpackage

// *** bench/pss_asserts.sv ***
/* port checker for pss_storm_ctrl.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ns
`default_nettype none
module pss_asserts #(
   parameter int INTERVAL_CYCLES = 100,
   parameter int PORT_MBPS = 1000
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // controls
   input wire logic clk_en,
   input wire logic act_shutdown,
   input wire logic act_trap,
   input wire logic port_reenable,
   // forwarding and status
   input wire logic fw_valid,
   input wire logic fw_ready,
   input wire pss_pkg::pss_frame_t fw_frame,
   input wire logic [2:0] storm_active,
   input wire logic port_disabled,
   input wire logic trap_event
);
   default clocking dck @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_stall; fw_valid && !fw_ready && clk_en; endsequence
   sequence s_push; $rose(fw_valid); endsequence
   chk_trap_pulse: assert property (trap_event |=> !trap_event)
      else $error("trap event longer than one cycle");
   chk_trap_gate: assert property (trap_event |-> $past(act_trap))
      else $error("trap event without trap enable");
   chk_shut_gate: assert property ($rose(port_disabled) |-> $past(act_shutdown))
      else $error("port shut without shutdown enable");
   chk_shut_hold: assert property (port_disabled && !port_reenable |=> port_disabled)
      else $error("shut port came back by itself");
   chk_word_stands: assert property (s_stall |=> fw_valid && $stable(fw_frame))
      else $error("forward word changed while stalled");
   chk_storm_block: assert property (s_push ##0 $past(|storm_active[2:1]) |->
      fw_frame.cls == pss_pkg::CLS_STP) else $error("frame passed a class storm");
   chk_bcast_block: assert property (s_push ##0 $past(storm_active[0]) |->
      fw_frame.cls != pss_pkg::CLS_BCAST) else $error("broadcast passed its storm");
   chk_shut_block: assert property (s_push |-> !$past(port_disabled))
      else $error("frame passed a shut port");
endmodule // pss_asserts
bind pss_storm_ctrl pss_asserts #(.INTERVAL_CYCLES(INTERVAL_CYCLES), .PORT_MBPS(PORT_MBPS)) CHK (
   .ref_clk, .arst_n, .clk_en, .act_shutdown, .act_trap, .port_reenable, .fw_valid,
   .fw_ready, .fw_frame, .storm_active, .port_disabled, .trap_event);
`default_nettype wire

// *** bench/pss_fwd_sink.sv ***
/* forwarding side model: accepts words with random stalls, and accepts none while hold is high.
   assumes the same clock and reset as the block. */
`timescale 1ns/1ns
`default_nettype none
module pss_fwd_sink (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // handshake
   input wire logic hold,
   output logic fw_ready
);
   // ready may drop under a standing word, as real forwarding logic does
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) fw_ready <= 1'b0;
      else fw_ready <= !hold && ($urandom % 3 != 0);
   end
endmodule // pss_fwd_sink
`default_nettype wire

// *** bench/pss_storm_ctrl_tb_top.sv ***
/* self-checking bench for pss_storm_ctrl with a short interval.
   assumes the checker bind and the forwarding sink model. */
`timescale 1ns/1ns
`default_nettype none
module pss_storm_ctrl_tb_top;
   logic ref_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, act_shutdown = 1'b0, act_trap = 1'b0;
   logic port_reenable = 1'b0, rx_valid = 1'b0, hold = 1'b0, ign = 1'b0;
   logic rx_ready, fw_valid, fw_ready, port_disabled, trap_event;
   logic [2:0] storm_active;
   logic [7:0] trap_cnt = 8'h00;
   pss_pkg::pss_class_cfg_t cb = '0, cm = '0, cu = '0;
   pss_pkg::pss_frame_t rx_frame = '0, fw_frame;
   pss_pkg::pss_frame_t q[$];
   int error_cnt = 0, total_checks = 0;
   initial forever #5 ref_clk = ~ref_clk;
   pss_storm_ctrl #(.INTERVAL_CYCLES(100), .PORT_MBPS(1000)) DUT (.ref_clk, .arst_n, .clk_en,
      .cfg_bcast(cb), .cfg_mcast(cm), .cfg_ucast(cu), .act_shutdown, .act_trap, .port_reenable,
      .rx_valid, .rx_ready, .rx_frame, .fw_valid, .fw_ready, .fw_frame, .storm_active,
      .port_disabled, .trap_event);
   pss_fwd_sink FWD (.ref_clk, .arst_n, .hold, .fw_ready);
   task cmp_frm(pss_pkg::pss_frame_t g, pss_pkg::pss_frame_t e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t frame %h exp %h", $time, g, e);
      end
   endtask
   task cmp_v(logic [7:0] g, logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task send(logic [1:0] c, logic [13:0] l, int gap, bit e);
      pss_pkg::pss_frame_t f;
      logic ok;
      f = {$urandom, $urandom, c, l};
      rx_frame <= f;
      rx_valid <= 1'b1;
      do begin
         @(negedge ref_clk) ok = rx_ready;
         @(posedge ref_clk);
      end while (!ok);
      if (e) q.push_back(f);
      if (gap > 0) begin
         rx_valid <= 1'b0;
         repeat (gap) @(posedge ref_clk);
      end
   endtask
   task drain;
      for (int k = 0; k < 300 && q.size() > 0; k++) @(posedge ref_clk);
   endtask
   // classes cycle through all four codes; fwd holds which of them should pass
   task stream(int n, logic [3:0] fwd);
      for (int i = 0; i < n; i++) send(2'(i % 4), 14'h0040, 2, fwd[i % 4]);
   endtask
   // the burst outlasts one full interval so detection never depends on phase
   task trig(logic [1:0] c, logic [13:0] l);
      drain();
      ign <= 1'b1;
      repeat (40) send(c, l, 3, 1'b0);
      for (int k = 0; k < 60 && fw_valid; k++) @(posedge ref_clk);
      ign <= 1'b0;
   endtask
   task chk(logic [3:0] e);
      @(negedge ref_clk) cmp_v({4'h0, storm_active, port_disabled}, {4'h0, e});
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      if (trap_event === 1'b1) trap_cnt <= trap_cnt + 8'h01;
      if (fw_valid === 1'b1 && fw_ready === 1'b1 && !ign) begin
         if (q.size() == 0) cmp_v(8'h01, 8'h00);
         else cmp_frm(fw_frame, q.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'hF7E643BC));
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk(4'h0);
      for (int i = 0; i < 40; i++) begin
         send(2'($urandom % 4), 14'($urandom % 1500), (i == 39) ? 1 : $urandom % 2, 1'b1);
      end
      drain();
      hold <= 1'b1;
      repeat (2) send(pss_pkg::CLS_UCAST, 14'h0040, 1, 1'b1);
      @(negedge ref_clk) cmp_v({7'h00, rx_ready}, 8'h00);
      @(posedge ref_clk) hold <= 1'b0;
      $display("test pass-through done");
      cm <= '{enable: 1'b1, pps_mode: 1'b1, fall_valid: 1'b1, rise_pps: 32'h4,
              fall_pps: 32'h2, default: '0};
      act_trap <= 1'b1;
      trig(pss_pkg::CLS_MCAST, 14'h0040);
      chk(4'b0100);
      cmp_v(trap_cnt, 8'h01);
      stream(24, 4'b1000);
      repeat (8) send(pss_pkg::CLS_MCAST, 14'h0040, 39, 1'b0);
      chk(4'b0100);
      repeat (250) @(posedge ref_clk);
      chk(4'h0);
      $display("test multicast storm done");
      cm <= '0;
      act_trap <= 1'b0;
      cb <= '{enable: 1'b1, pps_mode: 1'b1, rise_pps: 32'h4, default: '0};
      trig(pss_pkg::CLS_BCAST, 14'h0040);
      chk(4'b0010);
      stream(24, 4'b1110);
      repeat (250) @(posedge ref_clk);
      chk(4'h0);
      cmp_v(trap_cnt, 8'h01);
      $display("test broadcast storm done");
      cb <= '0;
      act_shutdown <= 1'b1;
      cu <= '{enable: 1'b1, pps_mode: 1'b1, rise_pps: 32'h4, default: '0};
      trig(pss_pkg::CLS_UCAST, 14'h0040);
      chk(4'b1001);
      cu <= '0;
      repeat (300) @(posedge ref_clk);
      chk(4'b0001);
      port_reenable <= 1'b1;
      @(posedge ref_clk) port_reenable <= 1'b0;
      act_shutdown <= 1'b0;
      chk(4'h0);
      $display("test shutdown done");
      cb <= '{enable: 1'b1, rise_pct: pss_pkg::PCT_FULL, default: '0};
      trig(pss_pkg::CLS_BCAST, 14'h03E8);
      chk(4'h0);
      cb <= '{enable: 1'b1, rise_pct: pss_pkg::PCT_FULL - 14'h0001, default: '0};
      trig(pss_pkg::CLS_BCAST, 14'h03E8);
      chk(4'b0010);
      cb <= '{enable: 1'b1, pps_mode: 1'b1, rise_pps: pss_pkg::PPS_FULL, default: '0};
      trig(pss_pkg::CLS_BCAST, 14'h0040);
      chk(4'h0);
      $display("test limits done");
      drain();
      cmp_v(8'(q.size()), 8'h00);
      report_and_stop();
   end
endmodule // pss_storm_ctrl_tb_top
`default_nettype wire
